// ---- rtl/lcdi_map.svh ----
`ifndef LCDI_MAP_SVH
`define LCDI_MAP_SVH
// Seven-bit slave addresses selected by the address strap.
`define LCDI_ADDR_STRAP_LO 7'h3c
`define LCDI_ADDR_STRAP_HI 7'h3d
// Control byte fields.
`define LCDI_CTRL_CONT_BIT 7
`define LCDI_CTRL_DC_BIT   6
// Status byte fields.
`define LCDI_STAT_BUSY_BIT 7
// Interface select codes on the two select pins (b,a).
`define LCDI_IFSEL_I2C     2'h0
`define LCDI_IFSEL_SERIAL  2'h1
// Reset value of the address pointer.
`define LCDI_PTR_RESET     7'h00
// Queue word: bit 8 carries the selector beside the payload byte.
`define LCDI_QUEUE_SEL_BIT 8
// Width-select instruction pattern and the bit carrying the width.
`define LCDI_WIDTH_MASK    8'he0
`define LCDI_WIDTH_CODE    8'h20
`define LCDI_WIDTH_BIT     4
// Last bit index of a byte, counted from zero.
`define LCDI_BIT_LAST      3'h7
// Link and system timing figures.
`define LCDI_CLK_SYS_HZ    40000000
`define LCDI_LINK_MAX_HZ   400000
`endif

// ---- rtl/lcdi_pkg.sv ----
package lcdi_pkg;
  // Host interface kind chosen by the select pins.
  typedef enum logic [1:0]
  {
    LCDI_IF_I2C    = 2'h0,
    LCDI_IF_SERIAL = 2'h1,
    LCDI_IF_PAR4   = 2'h2,
    LCDI_IF_PAR8   = 2'h3
  } lcdi_iface_t;
  // Byte parser states, one-hot.
  typedef enum logic [5:0]
  {
    LCDI_IDLE  = 6'h01,
    LCDI_ADDR  = 6'h02,
    LCDI_WRX   = 6'h04,
    LCDI_RDX   = 6'h08,
    LCDI_ACK   = 6'h10,
    LCDI_MACK  = 6'h20
  } lcdi_state_t;
endpackage

// ---- rtl/lcdi_fifo.sv ----
`timescale 1ns/100ps
// Small synchronous FIFO with valid and ready on both sides.
module lcdi_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Power-of-two depth keeps the pointer wrap free.
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("lcdi_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
  logic [AW:0]      wr_q;           // Write pointer with wrap bit.
  logic [AW:0]      rd_q;           // Read pointer with wrap bit.
  logic             push;
  logic             pop;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // Pointer update.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
    end
  end
  // Storage write; no reset needed on data.
  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// ---- rtl/lcdi_slave.sv ----
`timescale 1ns/100ps
`include "lcdi_map.svh"
// Overview of operation
// - Interface kind from select pins, width bit.
// - Works at link rates to 400 kbit/s.
// - Address 0111100 or 0111101 by strap.
// - Data sampled only on rising clock edges.
// - Falling data with clock high starts.
// - Rising data with clock high stops.
// - Acknowledge every received byte addressed here.
// - Hold data low through acknowledge pulse.
// - On master no-acknowledge release the line.
// - First byte is address plus direction.
// - Foreign address: silent until next start.
// - Write words: control byte then payload.
// - Cleared continuation flag: payloads until next start.
// - Selector one: payload goes to RAM.
// - Selector zero: payload is an instruction.
// - Read with selector zero returns status.
// - Line driven low only, else released.
// - Status: busy bit 7, pointer bits 6-0.
// - Staging register reloads after each read.
// - Pointer steps by one after RAM access.
module lcdi_slave #(
  parameter int FIFO_DEPTH = 8,
  parameter int RAM_WORDS  = 128
) (
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       iface_select_pin_a,
  input  wire logic       iface_select_pin_b,
  input  wire logic       addr_strap_pin,
  input  wire logic       entry_increment,
  input  wire logic       busy_in,
  output logic            i2c_active_q,
  output logic            parallel_width_bit,
  output logic            instr_valid_q,
  output logic      [7:0] instr_code_q,
  output logic      [6:0] ram_pointer_q
);
  // Clock must take several samples per link phase at the top rate.
  localparam int MIN_SAMPLES = 4;
  initial
  begin
    if (`LCDI_CLK_SYS_HZ / (2 * `LCDI_LINK_MAX_HZ) < MIN_SAMPLES)
      $error("system clock too slow for the link");
    if (RAM_WORDS != 128)
      $error("display RAM must match the 7-bit pointer");
  end

  logic [2:0] scl_sync_q;      // Two sync stages plus history.
  logic [2:0] sda_sync_q;      // Two sync stages plus history.
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  lcdi_pkg::lcdi_state_t state_q;   // Byte parser state.
  lcdi_pkg::lcdi_state_t after_ack_q; // State to enter after ack slot.
  logic [7:0] shift_q;         // Receive shift register.
  logic [2:0] bit_q;           // Bit index within the byte.
  logic       ctrl_next_q;     // Next written byte is a control byte.
  logic       payload_only_q;  // Continuation flag was cleared.
  logic       sel_data_q;      // Selector from the last control byte.
  logic       ack_drive_q;     // Acknowledge pending for this slot.
  logic [7:0] tx_q;            // Byte being sent on a read.
  logic [7:0] staging_q;       // RAM staging register.
  logic [7:0] ram_q [RAM_WORDS]; // Character display RAM.
  logic       width_q;         // Parallel width from instructions.
  logic       fifo_in_valid;
  logic       fifo_in_ready;
  logic [8:0] fifo_in_data;
  logic       fifo_out_valid;
  logic [8:0] fifo_out_data;
  logic       byte_done;
  logic [6:0] own_addr;
  logic [7:0] status_byte;
  logic [7:0] tx_next;         // Byte loaded at the start of a read byte.
  logic       load_q;          // Load a fresh read byte at the next fall.
  logic       rd_step_q;       // Pulse: a RAM byte went out on a read.
  logic       ram_wr;          // Drained payload goes to display RAM.
  logic       instr_take;      // Drained payload is an instruction.
  logic [2:0] pin_raw;         // Strap and select pins as they arrive.
  logic [2:0] pin_s1_q;        // First synchroniser stage of the pins.
  logic [2:0] pin_s2_q;        // Second synchroniser stage of the pins.

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  // Edges look only at the second and third stages.
  assign scl_rise   = scl_sync_q[1] && !scl_sync_q[2];
  assign scl_fall   = !scl_sync_q[1] && scl_sync_q[2];
  assign start_seen = scl_sync_q[1] && scl_sync_q[2] &&
                      !sda_sync_q[1] && sda_sync_q[2];
  assign stop_seen  = scl_sync_q[1] && scl_sync_q[2] &&
                      sda_sync_q[1] && !sda_sync_q[2];

  assign own_addr = pin_s2_q[2] ? `LCDI_ADDR_STRAP_HI
                                : `LCDI_ADDR_STRAP_LO;
  assign status_byte = {busy_in, ram_pointer_q};
  assign byte_done   = scl_rise && (bit_q == `LCDI_BIT_LAST);

  // Byte parser: sampling on rising clock, driving after falling clock.
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q        <= lcdi_pkg::LCDI_IDLE;
      after_ack_q    <= lcdi_pkg::LCDI_IDLE;
      shift_q        <= 8'h00;
      bit_q          <= 3'h0;
      ctrl_next_q    <= 1'b1;
      payload_only_q <= 1'b0;
      sel_data_q     <= 1'b0;
      ack_drive_q    <= 1'b0;
      load_q         <= 1'b0;
      rd_step_q      <= 1'b0;
      tx_q           <= 8'h00;
      sda_oe         <= 1'b0;
    end
    else if (start_seen && i2c_active_q)
    begin
      state_q        <= lcdi_pkg::LCDI_ADDR;
      bit_q          <= 3'h0;
      ctrl_next_q    <= 1'b1;
      payload_only_q <= 1'b0;
      ack_drive_q    <= 1'b0;
      load_q         <= 1'b0;
      rd_step_q      <= 1'b0;
      // A repeated start may come while a read bit holds the line.
      sda_oe         <= 1'b0;
    end
    else if (stop_seen)
    begin
      state_q     <= lcdi_pkg::LCDI_IDLE;
      ack_drive_q <= 1'b0;
      load_q      <= 1'b0;
      rd_step_q   <= 1'b0;
      sda_oe      <= 1'b0;
    end
    else
    begin
      // The read step is a pulse; only a byte load below raises it.
      rd_step_q <= 1'b0;
      unique case (state_q)
        lcdi_pkg::LCDI_IDLE:
        begin
          bit_q <= 3'h0;
        end
        lcdi_pkg::LCDI_ADDR, lcdi_pkg::LCDI_WRX:
        begin
          if (scl_rise)
          begin
            shift_q <= {shift_q[6:0], sda_sync_q[1]};
            bit_q   <= bit_q + 3'h1;
          end
          if (byte_done && state_q == lcdi_pkg::LCDI_ADDR)
          begin
            if (shift_q[6:0] == own_addr)
            begin
              ack_drive_q <= 1'b1;
              state_q     <= lcdi_pkg::LCDI_ACK;
              after_ack_q <= sda_sync_q[1] ? lcdi_pkg::LCDI_RDX
                                           : lcdi_pkg::LCDI_WRX;
            end
            else
            begin
              state_q <= lcdi_pkg::LCDI_IDLE;
            end
          end
          else if (byte_done)
          begin
            ack_drive_q <= 1'b1;
            state_q     <= lcdi_pkg::LCDI_ACK;
            after_ack_q <= lcdi_pkg::LCDI_WRX;
            if (ctrl_next_q && !payload_only_q)
            begin
              sel_data_q     <= shift_q[`LCDI_CTRL_DC_BIT-1];
              payload_only_q <= !shift_q[`LCDI_CTRL_CONT_BIT-1];
              ctrl_next_q    <= 1'b0;
            end
            else
            begin
              ctrl_next_q <= !payload_only_q;
            end
          end
        end
        lcdi_pkg::LCDI_RDX:
        begin
          // Bits leave after falling edges, while the clock is low.
          if (scl_fall && load_q)
          begin
            tx_q      <= tx_next;
            sda_oe    <= !tx_next[`LCDI_BIT_LAST];
            load_q    <= 1'b0;
            rd_step_q <= sel_data_q;
          end
          else if (scl_fall && bit_q != 3'h0)
          begin
            tx_q   <= {tx_q[6:0], 1'b1};
            sda_oe <= !tx_q[`LCDI_BIT_LAST - 3'h1];
          end
          if (scl_rise)
            bit_q <= bit_q + 3'h1;
          if (byte_done)
            state_q <= lcdi_pkg::LCDI_MACK;
        end
        lcdi_pkg::LCDI_ACK:
        begin
          if (scl_fall && ack_drive_q)
          begin
            sda_oe      <= 1'b1;
            ack_drive_q <= 1'b0;
          end
          else if (scl_fall)
          begin
            // The ninth fall ends the slot; a read hands bit 7 over here.
            state_q <= after_ack_q;
            if (after_ack_q == lcdi_pkg::LCDI_RDX)
            begin
              tx_q      <= tx_next;
              sda_oe    <= !tx_next[`LCDI_BIT_LAST];
              rd_step_q <= sel_data_q;
            end
            else
              sda_oe <= 1'b0;
          end
        end
        lcdi_pkg::LCDI_MACK:
        begin
          if (scl_fall)
            sda_oe <= 1'b0;
          if (scl_rise)
          begin
            state_q <= sda_sync_q[1] ? lcdi_pkg::LCDI_IDLE
                                     : lcdi_pkg::LCDI_RDX;
            load_q  <= !sda_sync_q[1];
          end
        end
      endcase
    end
  end

  assign tx_next = sel_data_q ? staging_q : status_byte;

  assign pin_raw = {addr_strap_pin, iface_select_pin_b, iface_select_pin_a};
  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_pin_sync
      // Strap and select pins are slow levels, yet still asynchronous.
      always_ff @(posedge clk_sys)
      begin
        if (!reset_n)
        begin
          pin_s1_q[i] <= 1'b0;
          pin_s2_q[i] <= 1'b0;
        end
        else
        begin
          pin_s1_q[i] <= pin_raw[i];
          pin_s2_q[i] <= pin_s1_q[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      i2c_active_q <= 1'b0;
    else
      i2c_active_q <= pin_s2_q[1:0] == `LCDI_IFSEL_I2C;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      fifo_in_valid <= 1'b0;
      fifo_in_data  <= 9'h000;
    end
    else
    begin
      // Control bytes stay in the parser; only payload is queued.
      fifo_in_valid <= byte_done && !start_seen && !stop_seen &&
                       state_q == lcdi_pkg::LCDI_WRX &&
                       !(ctrl_next_q && !payload_only_q);
      fifo_in_data  <= {sel_data_q, shift_q[6:0], sda_sync_q[1]};
    end
  end

  // A byte meeting a full queue would be lost; at the link's pace of
  // one byte per nine link clocks the queue never fills.
  lcdi_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out_data)
  );
  assign ram_wr     = fifo_out_valid && fifo_out_data[`LCDI_QUEUE_SEL_BIT];
  assign instr_take = fifo_out_valid && !fifo_out_data[`LCDI_QUEUE_SEL_BIT];

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      instr_valid_q <= 1'b0;
      instr_code_q  <= 8'h00;
      width_q       <= 1'b0;
    end
    else
    begin
      instr_valid_q <= instr_take;
      if (instr_take)
      begin
        instr_code_q <= fifo_out_data[7:0];
        if ((fifo_out_data[7:0] & `LCDI_WIDTH_MASK) == `LCDI_WIDTH_CODE)
          width_q <= fifo_out_data[`LCDI_WIDTH_BIT];
      end
    end
  end
  assign parallel_width_bit = width_q;

  always_ff @(posedge clk_sys)
  begin
    if (ram_wr)
      ram_q[ram_pointer_q] <= fifo_out_data[7:0];
    staging_q <= ram_q[ram_pointer_q];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      ram_pointer_q <= `LCDI_PTR_RESET;
    else if (ram_wr || rd_step_q)
      ram_pointer_q <= entry_increment ? ram_pointer_q + 7'h01
                                       : ram_pointer_q - 7'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    sda_out <= 1'b0;
  end
endmodule

// ---- verif/lcdi_slave_chk.sv ----
`timescale 1ns/100ps
// Pin-level watch on the slave port. The link gives four system cycles
// per clock phase, which bounds how late the port may move its driver.
module lcdi_slave_chk (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       i2c_active_q,
  input wire logic       instr_valid_q,
  input wire logic [6:0] ram_pointer_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_low_only; sda_oe |-> !sda_out; endproperty
  property p_quiet; !i2c_active_q |-> !sda_oe; endproperty
  property p_grab; $rose(sda_oe) |-> !scl_in; endproperty
  property p_drop; $fell(sda_oe) |-> !scl_in; endproperty
  property p_hold; $rose(sda_oe) |-> sda_oe [*4]; endproperty
  property p_one_instr; instr_valid_q |=> !instr_valid_q; endproperty
  // A pointer move is one step either way, never a jump.
  property p_step;
    $changed(ram_pointer_q) |->
      7'(ram_pointer_q - $past(ram_pointer_q)) inside {7'h01, 7'h7f};
  endproperty
  property p_pace;
    $changed(ram_pointer_q) |=> $stable(ram_pointer_q) [*8];
  endproperty
  a_low_only: assert property (p_low_only)
    else $error("data line driven high");
  a_quiet: assert property (p_quiet)
    else $error("data driven while port inactive");
  a_grab: assert property (p_grab)
    else $error("driver taken while clock high");
  a_drop: assert property (p_drop)
    else $error("driver dropped while clock high");
  a_hold: assert property (p_hold)
    else $error("low level not held over clock pulse");
  a_one_instr: assert property (p_one_instr)
    else $error("instruction strobe too long");
  a_step: assert property (p_step)
    else $error("pointer moved by more than one");
  a_pace: assert property (p_pace)
    else $error("pointer moved twice for one byte");
  cover property (instr_valid_q);
  cover property ($rose(sda_oe));
  cover property ($changed(ram_pointer_q));
endmodule

bind lcdi_slave lcdi_slave_chk u_chk (
  .clk_sys       (clk_sys),
  .reset_n       (reset_n),
  .scl_in        (scl_in),
  .sda_out       (sda_out),
  .sda_oe        (sda_oe),
  .i2c_active_q  (i2c_active_q),
  .instr_valid_q (instr_valid_q),
  .ram_pointer_q (ram_pointer_q)
);

// ---- verif/lcdi_host_model.sv ----
`timescale 1ns/100ps
// Bus master model. Only the data line is open drain; the clock stays high
// between frames, and a 200 ns link period is eight system cycles.
module lcdi_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // The bus starts idle, both lines released.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One quarter of a link period.
  task automatic q();
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic start();
    sda_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_low <= 1'b0;
    q();
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    r = sda_line;
    q();
    scl <= 1'b0;
    q();
  endtask
  // byte out, line released for the answer
  task automatic byte_tx(input logic [7:0] d, input int n,
                         output logic ack);
    logic r;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--)
      bit_x(d[i], r);
    if (n == 8)
    begin
      bit_x(1'b1, r);
      ack = ~r;
    end
  endtask
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bit_x(1'b1, r);
      d = {d[6:0], r};
    end
    bit_x(last, r);
  endtask
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
// Drives the slave port through the master model and checks its outputs.
module testbench;
  logic       clk_sys, reset_n, sel_a, sel_b, strap, entry_inc, busy;
  logic       scl, sda_low, sda_out, sda_oe, sda_line, ack, instr_v;
  logic [7:0] instr_code, instr_seen, rd;
  logic [6:0] ptr;
  logic       act, width;
  int         fail_count, samples_checked, instr_cnt;
  // The wire is low while either party pulls it, else the pull-up wins.
  assign sda_line = ~((sda_oe & ~sda_out) | sda_low);
  lcdi_slave dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .iface_select_pin_a(sel_a), .iface_select_pin_b(sel_b),
    .addr_strap_pin(strap), .entry_increment(entry_inc),
    .busy_in(busy), .i2c_active_q(act), .parallel_width_bit(width),
    .instr_valid_q(instr_v), .instr_code_q(instr_code),
    .ram_pointer_q(ptr)
  );
  lcdi_host_model host (
    .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Keeps the last decoded instruction and how many arrived.
  always @(posedge clk_sys)
    if (instr_v === 1'b1)
    begin
      instr_seen <= instr_code;
      instr_cnt <= instr_cnt + 1;
    end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
      fail_count++;
    end
  endtask
  task automatic send(input logic [7:0] b);
    host.byte_tx(b, 8, ack);
  endtask
  // The port hands bytes on through a queue, so allow it to drain.
  task automatic settle();
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
  initial
  begin
    {reset_n, sel_a, sel_b, strap, entry_inc, busy} = 6'h03;
    instr_cnt = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check({1'b0, ptr}, 8'h00);
    check({7'h00, act}, 8'h01);
    host.start();
    send(8'h78);
    check({7'h00, ack}, 8'h01);
    send(8'h00);
    check({7'h00, ack}, 8'h01);
    send(8'h0c);
    send(8'h30);
    host.stop();
    settle();
    check(instr_seen, 8'h30);
    check({7'h00, width}, 8'h01);
    check(8'(instr_cnt), 8'h02);
    host.start();
    send(8'h7a);
    check({7'h00, ack}, 8'h00);
    send(8'h00);
    check({7'h00, ack}, 8'h00);
    host.stop();
    host.start();
    send(8'h78);
    send(8'h40);
    for (int i = 0; i < 3; i++)
    begin
      send(8'h41 + 8'(i));
      check({7'h00, ack}, 8'h01);
    end
    host.stop();
    settle();
    check({1'b0, ptr}, 8'h03);
    check(8'(instr_cnt), 8'h02);
    strap <= 1'b1;
    entry_inc <= 1'b0;
    host.start();
    send(8'h7a);
    check({7'h00, ack}, 8'h01);
    send(8'h40);
    send(8'h55);
    host.stop();
    settle();
    check({1'b0, ptr}, 8'h02);
    host.start();
    send(8'h7a);
    send(8'h00);
    host.byte_tx(8'h0c, 4, ack);
    host.start();
    host.stop();
    settle();
    check(8'(instr_cnt), 8'h02);
    host.start();
    send(8'h7b);
    check({7'h00, ack}, 8'h01);
    host.byte_rx(1'b1, rd);
    host.stop();
    check(rd, 8'h82);
    wrap_up();
  end
endmodule
